// >>> bench/amx_host_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// host side of the register port
module amx_host_model (
    input  wire logic       clock,
    output var  logic [6:0] reg_addr,
    output var  logic       reg_wr,
    output var  logic       reg_rd,
    output var  logic [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    // idle lines at time zero
    initial begin
        reg_addr  = 7'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // one write pulse, then lines scrambled
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask
    // one read pulse, data taken after the edge
    task automatic rd(input logic [6:0] a, output logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask
endmodule // amx_host_model
`default_nettype wire

// >>> bench/amx_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// port checker for the readout block
module amx_monitor (
    input wire logic       clock,
    input wire logic       resetn,
    input wire logic       fast_rate,
    input wire logic       smp_x_stb,
    input wire logic [7:0] smp_x,
    input wire logic       smp_y_stb,
    input wire logic [7:0] smp_y,
    input wire logic       smp_z_stb,
    input wire logic [7:0] smp_z,
    input wire logic [6:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata,
    input wire logic       motion_irq
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    // ============================================================
    // helper state
    wire        rd_x   = reg_rd && (reg_addr == 7'h29);  // x output read
    wire        rd_st  = reg_rd && (reg_addr == 7'h27);  // status read
    wire        rd_src = reg_rd && (reg_addr == 7'h31);  // source read
    wire        any_stb = smp_x_stb | smp_y_stb | smp_z_stb;  // any sample
    logic [7:0] last_x_r;  // last x sample taken
    logic       x_pend_r;  // x sample not yet read
    logic       x_ovr_r;   // unread x sample overwritten
    // mirror of the x axis flags
    always @(posedge clock) begin
        if (!resetn) begin
            last_x_r <= 8'h00;
            x_pend_r <= 1'b0;
            x_ovr_r  <= 1'b0;
        end else begin
            if (smp_x_stb) begin
                last_x_r <= smp_x;
            end
            x_pend_r <= smp_x_stb | (x_pend_r & ~rd_x);
            x_ovr_r  <= (smp_x_stb & x_pend_r & ~rd_x) | (x_ovr_r & ~rd_x);
        end
    end
    // ============================================================
    // properties
    property p_rst_out;
        disable iff (1'b0) !resetn |=> (motion_irq == 1'b0) && (reg_rdata == 8'h00);
    endproperty
    a_rst_out: assert property (p_rst_out) else $error("outputs not cleared by reset");
    property p_unmapped;
        reg_rd && (reg_addr == 7'h28) |=> reg_rdata == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unused address not zero");
    property p_rdata_hold;
        !reg_rd |=> $stable(reg_rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_x_data;
        rd_x && !smp_x_stb |=> reg_rdata == last_x_r;
    endproperty
    a_x_data: assert property (p_x_data) else $error("x output wrong");
    property p_x_new;
        rd_st |=> reg_rdata[0] == $past(x_pend_r);
    endproperty
    a_x_new: assert property (p_x_new) else $error("x new flag wrong");
    property p_x_ovr;
        rd_st |=> reg_rdata[4] == $past(x_ovr_r);
    endproperty
    a_x_ovr: assert property (p_x_ovr) else $error("x overrun flag wrong");
    property p_src_ia;
        rd_src |=> (reg_rdata[6] == $past(motion_irq)) && !reg_rdata[7];
    endproperty
    a_src_ia: assert property (p_src_ia) else $error("active flag differs from irq");
    property p_src_clear;
        rd_src && !$past(any_stb) |=> !motion_irq;
    endproperty
    a_src_clear: assert property (p_src_clear) else $error("source read kept irq");
    property p_irq_rise;
        $rose(motion_irq) |-> $past(any_stb, 2);
    endproperty
    a_irq_rise: assert property (p_irq_rise) else $error("irq rose without sample");
    property p_irq_fall;
        $fell(motion_irq) |-> $past(rd_src) || $past(any_stb, 2);
    endproperty
    a_irq_fall: assert property (p_irq_fall) else $error("irq fell without cause");
    // ============================================================
    // coverage
    c_latched_read: cover property (rd_src && motion_irq);
    c_overrun: cover property (rd_st ##1 reg_rdata[7]);
    c_irq: cover property ($rose(motion_irq));
endmodule // amx_monitor

bind amx_top amx_monitor u_mon (.clock, .resetn, .fast_rate, .smp_x_stb, .smp_x,
    .smp_y_stb, .smp_y, .smp_z_stb, .smp_z, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata, .motion_irq);
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================
// self-checking bench for the readout block
module testbench;
    logic       clock;                      // 10 MHz
    logic       resetn;                     // active low
    logic       fast_rate;                  // output rate select
    logic       smp_x_stb, smp_y_stb, smp_z_stb;  // sample strobes
    logic [7:0] smp_x, smp_y, smp_z;        // sample values
    wire  [6:0] reg_addr;                   // register address
    wire        reg_wr, reg_rd;             // register strobes
    wire  [7:0] reg_wdata, reg_rdata;       // register data
    wire        motion_irq;                 // event request
    int         errors, checked, cyc;       // counters
    // cfg, x, y, z, expected source, compare mask
    logic [47:0] ev_tab [8] = '{48'h02_20_10_10_42_FF, 48'h02_10_10_10_00_FF,
        48'h01_05_10_10_41_FF, 48'h8A_20_10_10_02_FF, 48'h8A_20_20_10_4A_FF,
        48'h3F_10_20_05_58_FF, 48'h0A_E0_10_10_42_FF, 48'h00_20_10_10_00_40};
    // ============================================================
    // design and host
    amx_top #(.STEP_FAST_CYC(4), .STEP_SLOW_CYC(16)) dut (.clock, .resetn, .fast_rate,
        .smp_x_stb, .smp_x, .smp_y_stb, .smp_y, .smp_z_stb, .smp_z, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata, .motion_irq);
    amx_host_model host (.clock, .reg_addr, .reg_wr, .reg_rd, .reg_wdata, .reg_rdata);
    // clock
    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end
    // hang guard
    always @(posedge clock) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            wrap_up();
        end
    end
    // ============================================================
    // shared tasks
    task automatic wrap_up();
        if (errors == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [6:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        chk(d, exp);
    endtask
    // strobe chosen axes, wait until the source is updated
    task automatic smp(input logic [2:0] m, input logic [7:0] x, y, z);
        @(posedge clock);
        {smp_z_stb, smp_y_stb, smp_x_stb} <= m;
        {smp_x, smp_y, smp_z} <= {x, y, z};
        @(posedge clock);
        {smp_z_stb, smp_y_stb, smp_x_stb} <= 3'b000;
        {smp_x, smp_y, smp_z} <= ~{x, y, z};
        repeat (2) @(posedge clock);
        #1;
    endtask
    // ============================================================
    // scenarios
    task automatic t_reset();
        rchk(7'h27, 8'h00);
        rchk(7'h30, 8'h00);
        rchk(7'h31, 8'h00);
        rchk(7'h32, 8'h02);
        rchk(7'h33, 8'h00);
        rchk(7'h28, 8'h00);
        host.wr(7'h27, 8'hFF);
        rchk(7'h27, 8'h00);
    endtask
    task automatic t_status();
        smp(3'b001, 8'h11, 8'h00, 8'h00);
        rchk(7'h27, 8'h01);
        smp(3'b001, 8'h22, 8'h00, 8'h00);
        rchk(7'h27, 8'h11);
        rchk(7'h29, 8'h22);
        rchk(7'h27, 8'h00);
        smp(3'b111, 8'h81, 8'h7F, 8'hF0);
        rchk(7'h27, 8'h0F);
        smp(3'b111, 8'h80, 8'h01, 8'hFE);
        rchk(7'h27, 8'hFF);
        rchk(7'h2D, 8'hFE);
        rchk(7'h2B, 8'h01);
        rchk(7'h29, 8'h80);
        rchk(7'h27, 8'h00);
    endtask
    task automatic t_events();
        logic [7:0] d;
        host.wr(7'h32, 8'h10);
        rchk(7'h32, 8'h10);
        for (int i = 0; i < 8; i++) begin
            host.wr(7'h30, ev_tab[i][47:40]);
            smp(3'b111, ev_tab[i][39:32], ev_tab[i][31:24], ev_tab[i][23:16]);
            chk({7'h00, motion_irq}, {7'h00, ev_tab[i][14]});
            host.rd(7'h31, d);
            chk(d & ev_tab[i][7:0], ev_tab[i][15:8]);
        end
    endtask
    task automatic t_latch();
        host.wr(7'h30, 8'h42);
        rchk(7'h30, 8'h42);
        smp(3'b111, 8'h20, 8'h10, 8'h10);
        smp(3'b111, 8'h10, 8'h10, 8'h10);
        chk({7'h00, motion_irq}, 8'h01);
        rchk(7'h31, 8'h42);
        chk({7'h00, motion_irq}, 8'h00);
        rchk(7'h31, 8'h00);
    endtask
    // condition low for off cycles (20 spans a slow step, so the counter
    // restarts), then held for w cycles, expect e; t picks counter mode
    task automatic t_dur(input logic r, input logic [7:0] t, input int off, input int w,
                         input logic [7:0] e);
        @(posedge clock);
        fast_rate <= r;
        host.wr(7'h32, t);
        host.wr(7'h30, 8'h02);
        host.wr(7'h33, 8'h03);
        smp(3'b111, 8'h10, 8'h10, 8'h10);
        repeat (off) @(posedge clock);
        smp(3'b111, 8'h20, 8'h10, 8'h10);
        rchk(7'h31, 8'h02);
        repeat (w) @(posedge clock);
        smp(3'b111, 8'h20, 8'h10, 8'h10);
        rchk(7'h31, e);
    endtask
    // ============================================================
    // main sequence
    initial begin
        resetn = 1'b0;
        fast_rate = 1'b1;
        {smp_x_stb, smp_y_stb, smp_z_stb} = 3'b000;
        {smp_x, smp_y, smp_z} = 24'h000000;
        errors = 0;
        checked = 0;
        cyc = 0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        t_reset();
        t_status();
        t_events();
        t_latch();
        t_dur(1'b1, 8'h10, 20, 16, 8'h42);
        t_dur(1'b0, 8'h10, 20, 16, 8'h02);
        t_dur(1'b0, 8'h10, 20, 64, 8'h42);
        // one fast step low only takes 3 down to 2; back up to 3 soon after
        t_dur(1'b1, 8'h90, 0, 0, 8'h42);
        wrap_up();
    end
endmodule // testbench
`default_nettype wire

// >>> common/amx_map.vh
`ifndef AMX_MAP_VH
`define AMX_MAP_VH

// ============================================================
// register offsets (7-bit register address)
`define AMX_ADDR_STATUS     7'h27
`define AMX_ADDR_OUT_X      7'h29
`define AMX_ADDR_OUT_Y      7'h2B
`define AMX_ADDR_OUT_Z      7'h2D
`define AMX_ADDR_EVT_CFG    7'h30
`define AMX_ADDR_EVT_SRC    7'h31
`define AMX_ADDR_EVT_THS    7'h32
`define AMX_ADDR_EVT_DUR    7'h33

// ============================================================
// reset values
`define AMX_RST_STATUS      8'h00
`define AMX_RST_EVT_CFG     8'h00
`define AMX_RST_EVT_SRC     7'h00
`define AMX_RST_EVT_THS     8'h02
`define AMX_RST_EVT_DUR     8'h00
`define AMX_RST_SAMPLE      8'h00

// ============================================================
// field positions
`define AMX_CFG_AOI_BIT     7
`define AMX_CFG_LIR_BIT     6
`define AMX_SRC_IA_BIT      6
`define AMX_THS_DURATION_DECREMENT_MODE_BIT    7

// ============================================================
// timing: clock period and duration step times
`define AMX_CLK_PERIOD_NS   100
`define AMX_STEP_FAST_NS    2500000
`define AMX_STEP_SLOW_NS    10000000
`define AMX_STEP_FAST_CYC   (`AMX_STEP_FAST_NS / `AMX_CLK_PERIOD_NS)
`define AMX_STEP_SLOW_CYC   (`AMX_STEP_SLOW_NS / `AMX_CLK_PERIOD_NS)

`endif

// >>> hdl/amx_axis_chan.v
`timescale 1ns/1ns
`default_nettype none
`include "amx_map.vh"

// ============================================================
// one axis: sample holder with new-data and overrun flags
module amx_axis_chan (
    input  wire       clock,      // system clock
    input  wire       resetn,     // synchronous reset, active low
    input  wire       smp_stb,    // fresh sample pulse
    input  wire [7:0] smp_in,     // fresh sample value
    input  wire       rd_clr,     // host read of this axis output
    output reg  [7:0] data_r,     // held two's-complement sample
    output reg        new_r,      // new sample available
    output reg        ovr_r       // unread sample overwritten
);

    // ============================================================
    // sample store and flags; a fresh sample wins over a read clear of the new flag, but a read in the same cycle clears overrun
    always @(posedge clock) begin
        if (!resetn) begin
            data_r <= `AMX_RST_SAMPLE;
            new_r  <= 1'b0;
            ovr_r  <= 1'b0;
        end else begin
            if (smp_stb) begin
                data_r <= smp_in;
            end
            if (smp_stb) begin
                new_r <= 1'b1;
            end else if (rd_clr) begin
                new_r <= 1'b0;
            end
            if (smp_stb && new_r && !rd_clr) begin
                ovr_r <= 1'b1;
            end else if (rd_clr) begin
                ovr_r <= 1'b0;
            end
        end
    end

endmodule // amx_axis_chan

`default_nettype wire

// >>> hdl/amx_step_div.v
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// duration step divider: one-cycle tick per output-rate step
module amx_step_div #(
    parameter FAST_CYC = 25000,   // cycles per fast-rate step
    parameter SLOW_CYC = 100000   // cycles per slow-rate step
) (
    input  wire clock,            // system clock
    input  wire resetn,           // synchronous reset, active low
    input  wire fast_rate,        // 1: fast output rate selected
    output reg  tick_r            // step pulse
);

    reg  [16:0] cnt_r;            // cycles into current step
    wire [16:0] last;             // terminal count for chosen rate

    assign last = fast_rate ? FAST_CYC[16:0] - 17'h00001
                            : SLOW_CYC[16:0] - 17'h00001;

    // ============================================================
    // count up the step, restart on rate change overshoot
    always @(posedge clock) begin
        if (!resetn) begin
            cnt_r  <= 17'h00000;
            tick_r <= 1'b0;
        end else if (cnt_r >= last) begin
            cnt_r  <= 17'h00000;
            tick_r <= 1'b1;
        end else begin
            cnt_r  <= cnt_r + 17'h00001;
            tick_r <= 1'b0;
        end
    end

endmodule // amx_step_div

`default_nettype wire

// >>> hdl/amx_top.v
// What this block does
// - combined overrun when unread set replaced
// - per-axis overrun when unread sample replaced
// - combined new flag when full set ready
// - per-axis new flag on fresh sample
// - signed 8-bit outputs at 29h,2Bh,2Dh
// - combine bit: 0 OR, 1 AND
// - latch bit holds detected request
// - latched source cleared only by host read
// - high enables allow above-threshold requests
// - low enables allow below-threshold requests
// - interrupt-active flag when events generated
// - Z/Y high and low source flags
// - event configuration resets to zero
// - X high and low source flags
// - source read clears source and interrupt
// - 7-bit threshold, top bit picks decrement
// - duration counts steps, frozen while latched
`timescale 1ns/1ns
`default_nettype none
`include "amx_map.vh"

module amx_top #(
    parameter STEP_FAST_CYC = `AMX_STEP_FAST_CYC,   // cycles per fast step
    parameter STEP_SLOW_CYC = `AMX_STEP_SLOW_CYC    // cycles per slow step
) (
    input  wire       clock,        // system clock, 10 MHz
    input  wire       resetn,       // synchronous reset, active low
    input  wire       fast_rate,    // output rate: 1 fast, 0 slow
    input  wire       smp_x_stb,    // fresh x sample pulse
    input  wire [7:0] smp_x,        // x sample
    input  wire       smp_y_stb,    // fresh y sample pulse
    input  wire [7:0] smp_y,        // y sample
    input  wire       smp_z_stb,    // fresh z sample pulse
    input  wire [7:0] smp_z,        // z sample
    input  wire [6:0] reg_addr,     // register address
    input  wire       reg_wr,       // register write strobe
    input  wire       reg_rd,       // register read strobe
    input  wire [7:0] reg_wdata,    // register write data
    output reg  [7:0] reg_rdata,    // register read data
    output reg        motion_irq    // motion event request
);

    // ============================================================
    // helper functions

    // magnitude of a signed sample, saturated to 7 bits
    function [6:0] mag;
        input [7:0] s;
        reg   [7:0] a;
        begin
            a = s[7] ? (~s + 8'h01) : s;
            mag = a[7] ? 7'h7F : a[6:0];
        end
    endfunction

    // read strobe aimed at one address
    function rd_at;
        input       rd;
        input [6:0] addr;
        input [6:0] target;
        begin
            rd_at = rd && (addr == target);
        end
    endfunction

    // ============================================================
    // declarations
    wire [7:0] x_data;              // held x sample
    wire [7:0] y_data;              // held y sample
    wire [7:0] z_data;              // held z sample
    wire       x_new;               // x new-data flag
    wire       y_new;               // y new-data flag
    wire       z_new;               // z new-data flag
    wire       x_ovr;               // x overrun flag
    wire       y_ovr;               // y overrun flag
    wire       z_ovr;               // z overrun flag
    wire       rd_x;                // host reads x output
    wire       rd_y;                // host reads y output
    wire       rd_z;                // host reads z output
    wire       rd_src;              // host reads event source
    wire       any_stb;             // any fresh sample
    wire       step_tick;           // duration step pulse

    reg        all_new_r;           // combined new-data flag
    reg        all_new_nxt;
    reg        all_ovr_r;           // combined overrun flag
    reg        all_ovr_nxt;
    reg  [7:0] cfg_r;               // event configuration
    reg  [7:0] ths_r;               // threshold and counter mode
    reg  [7:0] dur_r;               // event duration in steps
    reg  [6:0] src_r;               // event source flags
    reg  [6:0] src_nxt;
    reg  [7:0] cnt_r;               // duration counter
    reg  [7:0] cnt_nxt;
    reg        eval_r;              // evaluate after a sample lands
    reg  [5:0] ev;                  // enabled raw events
    reg        cond;                // combined interrupt condition
    reg        fire;                // condition held long enough
    reg  [7:0] rdata_nxt;

    wire       and_or_combine;                 // and_or_combine
    wire       latch_request;                 // latch_request
    wire [5:0] en;                  // axis event enables
    wire       duration_decrement_mode;                // duration_decrement_mode
    wire [6:0] ths;                 // threshold value

    assign and_or_combine     = cfg_r[`AMX_CFG_AOI_BIT];
    assign latch_request     = cfg_r[`AMX_CFG_LIR_BIT];
    assign en      = cfg_r[5:0];
    assign duration_decrement_mode    = ths_r[`AMX_THS_DURATION_DECREMENT_MODE_BIT];
    assign ths     = ths_r[6:0];
    assign rd_x    = rd_at(reg_rd, reg_addr, `AMX_ADDR_OUT_X);
    assign rd_y    = rd_at(reg_rd, reg_addr, `AMX_ADDR_OUT_Y);
    assign rd_z    = rd_at(reg_rd, reg_addr, `AMX_ADDR_OUT_Z);
    assign rd_src  = rd_at(reg_rd, reg_addr, `AMX_ADDR_EVT_SRC);
    assign any_stb = smp_x_stb | smp_y_stb | smp_z_stb;

    // ============================================================
    // axis channels
    amx_axis_chan u_chan_x (
        .clock  (clock),
        .resetn (resetn),
        .smp_stb(smp_x_stb),
        .smp_in (smp_x),
        .rd_clr (rd_x),
        .data_r (x_data),
        .new_r  (x_new),
        .ovr_r  (x_ovr)
    );

    amx_axis_chan u_chan_y (
        .clock  (clock),
        .resetn (resetn),
        .smp_stb(smp_y_stb),
        .smp_in (smp_y),
        .rd_clr (rd_y),
        .data_r (y_data),
        .new_r  (y_new),
        .ovr_r  (y_ovr)
    );

    amx_axis_chan u_chan_z (
        .clock  (clock),
        .resetn (resetn),
        .smp_stb(smp_z_stb),
        .smp_in (smp_z),
        .rd_clr (rd_z),
        .data_r (z_data),
        .new_r  (z_new),
        .ovr_r  (z_ovr)
    );

    // ============================================================
    // duration step source
    amx_step_div #(
        .FAST_CYC(STEP_FAST_CYC),
        .SLOW_CYC(STEP_SLOW_CYC)
    ) u_step (
        .clock    (clock),
        .resetn   (resetn),
        .fast_rate(fast_rate),
        .tick_r   (step_tick)
    );

    // ============================================================
    // combined data flags
    always @* begin
        all_new_nxt = all_new_r;
        all_ovr_nxt = all_ovr_r;
        // cleared once every axis has been read
        if (!x_new && !y_new && !z_new) begin
            all_new_nxt = 1'b0;
            all_ovr_nxt = 1'b0;
        end
        // full set ready
        if (x_new && y_new && z_new) begin
            all_new_nxt = 1'b1;
        end
        // fresh data while a full set is still unread
        if (any_stb && all_new_r) begin
            all_ovr_nxt = 1'b1;
        end
    end

    // ============================================================
    // event comparison and combining
    always @* begin
        ev[5] = (mag(z_data) > ths) & en[5];
        ev[4] = (mag(z_data) < ths) & en[4];
        ev[3] = (mag(y_data) > ths) & en[3];
        ev[2] = (mag(y_data) < ths) & en[2];
        ev[1] = (mag(x_data) > ths) & en[1];
        ev[0] = (mag(x_data) < ths) & en[0];
        if (and_or_combine) begin
            cond = (en != 6'h00) && (ev == en);
        end else begin
            cond = |ev;
        end
        fire = cond && (cnt_r >= dur_r);
    end

    // ============================================================
    // duration counter
    always @* begin
        cnt_nxt = cnt_r;
        if (latch_request && src_r[`AMX_SRC_IA_BIT]) begin
            cnt_nxt = cnt_r;
        end else if (step_tick) begin
            if (cond) begin
                // count up to the duration and hold
                if (cnt_r < dur_r) begin
                    cnt_nxt = cnt_r + 8'h01;
                end
            end else if (duration_decrement_mode) begin
                // decrement mode
                if (cnt_r != 8'h00) begin
                    cnt_nxt = cnt_r - 8'h01;
                end
            end else begin
                // reset mode
                cnt_nxt = 8'h00;
            end
        end
    end

    // ============================================================
    // event source register
    always @* begin
        src_nxt = src_r;
        // host read releases the source
        if (rd_src) begin
            src_nxt = `AMX_RST_EVT_SRC;
        end
        if (latch_request) begin
            // latch a request unless one is still held
            if (eval_r && fire && (!src_r[`AMX_SRC_IA_BIT] || rd_src)) begin
                src_nxt = {1'b1, ev};
            end
        end else if (eval_r) begin
            // follow the latest comparison
            src_nxt = {fire, ev};
        end
    end

    // ============================================================
    // read data mux; unmapped addresses read zero
    always @* begin
        case (reg_addr)
            `AMX_ADDR_STATUS:  rdata_nxt = {all_ovr_r, z_ovr, y_ovr, x_ovr,
                                            all_new_r, z_new, y_new, x_new};
            `AMX_ADDR_OUT_X:   rdata_nxt = x_data;
            `AMX_ADDR_OUT_Y:   rdata_nxt = y_data;
            `AMX_ADDR_OUT_Z:   rdata_nxt = z_data;
            `AMX_ADDR_EVT_CFG: rdata_nxt = cfg_r;
            `AMX_ADDR_EVT_SRC: rdata_nxt = {1'b0, src_r};
            `AMX_ADDR_EVT_THS: rdata_nxt = ths_r;
            `AMX_ADDR_EVT_DUR: rdata_nxt = dur_r;
            default:           rdata_nxt = 8'h00;
        endcase
    end

    // ============================================================
    // state registers
    always @(posedge clock) begin
        if (!resetn) begin
            all_new_r  <= 1'b0;
            all_ovr_r  <= 1'b0;
            cfg_r      <= `AMX_RST_EVT_CFG;
            ths_r      <= `AMX_RST_EVT_THS;
            dur_r      <= `AMX_RST_EVT_DUR;
            src_r      <= `AMX_RST_EVT_SRC;
            cnt_r      <= 8'h00;
            eval_r     <= 1'b0;
            reg_rdata  <= 8'h00;
            motion_irq <= 1'b0;
        end else begin
            all_new_r  <= all_new_nxt;
            all_ovr_r  <= all_ovr_nxt;
            src_r      <= src_nxt;
            cnt_r      <= cnt_nxt;
            eval_r     <= any_stb;
            motion_irq <= src_nxt[`AMX_SRC_IA_BIT];
            // register writes
            if (reg_wr) begin
                case (reg_addr)
                    `AMX_ADDR_EVT_CFG: cfg_r <= reg_wdata;
                    `AMX_ADDR_EVT_THS: ths_r <= reg_wdata;
                    `AMX_ADDR_EVT_DUR: dur_r <= reg_wdata;
                    default:           cfg_r <= cfg_r;
                endcase
            end
            // read data captured on the read strobe
            if (reg_rd) begin
                reg_rdata <= rdata_nxt;
            end
        end
    end

endmodule // amx_top

`default_nettype wire

// >>> hdl/amx_unused_placeholder_none.v
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire
